// >>> src/dac_params.svh
// Purpose: Offsets, field positions, reset values for the converter register block
// Assumes: 8-bit special-function-register space
// Notes:   Control register offset is chosen locally
`ifndef DAC_PARAMS_SVH
`define DAC_PARAMS_SVH

`define DAC_DATA_LOW_ADDR     8'hfb
`define DAC_DATA_HIGH_ADDR    8'hfc
`define DAC_CONTROL_ADDR      8'hfd
`define DAC_DATA_LOW_RESET    8'h00
`define DAC_DATA_HIGH_RESET   8'h00
`define DAC_CONTROL_RESET     8'h00
`define DAC_CTRL_ENABLE_BIT   0
`define DAC_CTRL_CLEAR_N_BIT  1
`define DAC_CTRL_RANGE_BIT    2
`define DAC_CTRL_EIGHT_BIT    3
`define DAC_CTRL_PIN_BIT      4
`define DAC_CTRL_USED_MASK    8'h1f
`define DAC_HIGH_USED_MASK    8'h0f

`endif

// >>> src/dac_pkg.sv
// Purpose: Types for the converter register block
// Assumes: Nothing
// Notes:   Constants live in dac_params.svh
package dac_pkg;
    typedef enum logic [0:0] {
        DAC_PIN_DEFAULT   = 1'b0,
        DAC_PIN_ALTERNATE = 1'b1
    } dac_pin_t;
    typedef enum logic [0:0] {
        DAC_RANGE_REF    = 1'b0,
        DAC_RANGE_SUPPLY = 1'b1
    } dac_range_t;
endpackage

// >>> src/dac_code_reg.sv
// Purpose: Registered converter code holder with load strobe
// Assumes: Synchronous active-high reset
// Notes:   Code output always from a flip-flop
`timescale 1ns/1ps
module dac_code_reg
    import dac_pkg::*;
#(
    parameter int WIDTH = 12
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] code_in,
    output logic      [WIDTH-1:0] code_out
);
    logic [WIDTH-1:0] next_code;

    always_comb begin
        next_code = code_out;
        if (load) begin
            next_code = code_in;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            code_out <= '0;
        end else begin
            code_out <= next_code;
        end
    end
endmodule

// >>> src/dac_register_control.sv
// Purpose: Control and data registers for a 12-bit voltage-output converter
// Assumes: Core special-function-register write/read strobes, one clock
// Notes:   Reads are combinational on the same cycle as the address
`timescale 1ns/1ps
`include "dac_params.svh"
module dac_register_control
    import dac_pkg::*;
#(
    parameter int CODE_WIDTH = 12
) (
    input  wire logic                  clock,
    input  wire logic                  sys_rst,
    input  wire logic [7:0]            sfr_addr,
    input  wire logic                  sfr_write,
    input  wire logic                  sfr_read,
    input  wire logic [7:0]            sfr_wdata,
    output logic      [7:0]            sfr_rdata,
    output logic                       sfr_hit,
    output logic      [CODE_WIDTH-1:0] converter_code,
    output logic                       converter_enable,
    output logic                       output_drive_en,
    output dac_pin_t                   output_pin_select,
    output dac_range_t                 range_select,
    output logic                       eight_bit_mode,
    output logic                       data_clear_n
);
    logic [7:0] converter_control;
    logic [7:0] converter_data_low;
    logic [7:0] converter_data_high;
    logic [7:0] next_control;
    logic [7:0] next_low;
    logic [7:0] next_high;
    logic       code_load;
    logic [CODE_WIDTH-1:0] code_value;

    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] target);
        addr_is = (a == target);
    endfunction

    logic wr_low;
    logic wr_high;
    logic wr_ctrl;
    assign wr_low  = sfr_write && addr_is(sfr_addr, `DAC_DATA_LOW_ADDR);
    assign wr_high = sfr_write && addr_is(sfr_addr, `DAC_DATA_HIGH_ADDR);
    assign wr_ctrl = sfr_write && addr_is(sfr_addr, `DAC_CONTROL_ADDR);

    // Register next values
    always_comb begin
        next_control = converter_control;
        next_low     = converter_data_low;
        next_high    = converter_data_high;
        if (wr_ctrl) begin
            next_control = sfr_wdata & `DAC_CTRL_USED_MASK;
        end
        if (wr_low) begin
            next_low = sfr_wdata;
        end
        if (wr_high) begin
            next_high = sfr_wdata;
        end
        if (!next_control[`DAC_CTRL_CLEAR_N_BIT]) begin
            next_low  = 8'h00;
            next_high = 8'h00;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            converter_control   <= `DAC_CONTROL_RESET;
            converter_data_low  <= `DAC_DATA_LOW_RESET;
            converter_data_high <= `DAC_DATA_HIGH_RESET;
        end else begin
            converter_control   <= next_control;
            converter_data_low  <= next_low;
            converter_data_high <= next_high;
        end
    end

    // Code formation from the values being written
    always_comb begin
        if (next_control[`DAC_CTRL_EIGHT_BIT]) begin
            code_value = {next_low, 4'h0};
        end else begin
            code_value = {next_high[3:0], next_low};
        end
    end

    // Low write loads the code; clear and mode change also refresh it
    assign code_load = wr_low || wr_ctrl;

    dac_code_reg #(
        .WIDTH(CODE_WIDTH)
    ) u_code (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .load     (code_load),
        .code_in  (code_value),
        .code_out (converter_code)
    );

    assign converter_enable  = converter_control[`DAC_CTRL_ENABLE_BIT];
    assign output_drive_en   = converter_control[`DAC_CTRL_ENABLE_BIT];
    assign output_pin_select = dac_pin_t'(converter_control[`DAC_CTRL_PIN_BIT]);
    assign range_select      = dac_range_t'(converter_control[`DAC_CTRL_RANGE_BIT]);
    assign eight_bit_mode    = converter_control[`DAC_CTRL_EIGHT_BIT];
    assign data_clear_n      = converter_control[`DAC_CTRL_CLEAR_N_BIT];

    // Read mux; unmapped addresses read zero with no hit
    always_comb begin
        sfr_rdata = 8'h00;
        sfr_hit   = 1'b0;
        if (sfr_read || sfr_write) begin
            if (addr_is(sfr_addr, `DAC_DATA_LOW_ADDR)) begin
                sfr_rdata = converter_data_low;
                sfr_hit   = 1'b1;
            end else if (addr_is(sfr_addr, `DAC_DATA_HIGH_ADDR)) begin
                sfr_rdata = converter_data_high;
                sfr_hit   = 1'b1;
            end else if (addr_is(sfr_addr, `DAC_CONTROL_ADDR)) begin
                sfr_rdata = converter_control & `DAC_CTRL_USED_MASK;
                sfr_hit   = 1'b1;
            end
        end
        if (!sfr_read) begin
            sfr_rdata = 8'h00;
        end
    end
endmodule

// >>> tb/dac_rc_props.sv
// Purpose: Port checker for dac_register_control
// Assumes: Bound to the top module
// Notes:   Writes matched by address
`timescale 1ns/1ps
module dac_rc_props (
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic [7:0]  sfr_addr,
    input wire logic        sfr_write,
    input wire logic [7:0]  sfr_wdata,
    input wire logic [11:0] converter_code,
    input wire logic        converter_enable,
    input wire logic        output_drive_en,
    input wire logic        eight_bit_mode,
    input wire logic        data_clear_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence s_low;
        sfr_write && sfr_addr == 8'hfb && data_clear_n;
    endsequence
    sequence s_ctl;
        sfr_write && sfr_addr == 8'hfd;
    endsequence
    AST_LOW: assert property (s_low ##0 !eight_bit_mode
        |=> converter_code[7:0] == $past(sfr_wdata)) else $error("low");
    AST_EIGHT: assert property (s_low ##0 eight_bit_mode
        |=> converter_code == {$past(sfr_wdata), 4'h0}) else $error("eight");
    AST_CLR: assert property (!data_clear_n |-> converter_code == 12'h000)
        else $error("clear");
    AST_DRV: assert property ($fell(sys_rst) |-> !output_drive_en && !converter_enable
        && converter_code == 12'h000) else $error("drive");
    AST_HOLD: assert property (!sfr_write |=> $stable(converter_code))
        else $error("hold");
    AST_HIGH: assert property (sfr_write && sfr_addr == 8'hfc
        |=> $stable(converter_code)) else $error("high");
    AST_CTL: assert property (s_ctl
        |=> {data_clear_n, converter_enable} == $past(sfr_wdata[1:0])) else $error("ctl");
    AST_MODE: assert property (s_ctl
        |=> eight_bit_mode == $past(sfr_wdata[3])) else $error("mode");
endmodule
bind dac_register_control dac_rc_props dac_rc_props_inst (.*);

// >>> tb/dac_analog_model.sv
// Purpose: Resistor string and buffer model
// Assumes: Pull-down on both pins
// Notes:   Levels in millivolts
`timescale 1ns/1ps
module dac_analog_model
    import dac_pkg::*;
#(
    parameter int SUPPLY_MV = 32'h0ce4
) (
    input  wire logic [11:0] code,
    input  wire logic        drive_en,
    input  wire dac_pin_t    pin,
    input  wire dac_range_t  range,
    output logic      [15:0] def_mv,
    output logic      [15:0] alt_mv
);
    logic [31:0] lvl;
    assign lvl = code * (range == DAC_RANGE_SUPPLY ? SUPPLY_MV : 32'h09c4) / 32'h1000;
    // Released pin sits at the pull-down
    assign def_mv = drive_en && pin == DAC_PIN_DEFAULT ? lvl[15:0] : 16'h0000;
    assign alt_mv = drive_en && pin == DAC_PIN_ALTERNATE ? lvl[15:0] : 16'h0000;
endmodule

// >>> tb/test_dac_register_control.sv
// Purpose: Self-checking bench for dac_register_control
// Assumes: One-cycle write strobes
// Notes:   Rows, then pin, reset, unmapped
`timescale 1ns/1ps
module test_dac_register_control
    import dac_pkg::*;
;
    typedef struct {logic [7:0] a, d, r; logic [11:0] c;} dac_row_t;
    logic        clock = 1'b0, sys_rst = 1'b1, sfr_write = 1'b0, sfr_read = 1'b0;
    logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic [11:0] converter_code;
    logic        converter_enable, output_drive_en, eight_bit_mode, data_clear_n, sfr_hit;
    dac_pin_t    output_pin_select;
    dac_range_t  range_select;
    logic [15:0] def_mv, alt_mv;
    int          fail_count = 0, total_checks = 0;
    dac_row_t    rows [8] = '{'{8'hfd, 8'hff, 8'h1f, 12'h000}, '{8'hfb, 8'hab, 8'hab, 12'hab0},
        '{8'hfd, 8'h03, 8'h03, 12'h0ab}, '{8'hfc, 8'hf5, 8'hf5, 12'h0ab},
        '{8'hfb, 8'h34, 8'h34, 12'h534}, '{8'hfd, 8'h01, 8'h01, 12'h000},
        '{8'hfd, 8'h03, 8'h03, 12'h000}, '{8'hfb, 8'h07, 8'h07, 12'h007}};
    dac_register_control dac_register_control_inst (.*);
    dac_analog_model dac_analog_model_inst (.code(converter_code), .drive_en(output_drive_en),
        .pin(output_pin_select), .range(range_select), .def_mv(def_mv), .alt_mv(alt_mv));
    initial begin
        forever #25 clock = ~clock;
    end
    task automatic chk(input string n, input logic [15:0] e, g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clock);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_write <= 1'b1;
        @(posedge clock);
        sfr_write <= 1'b0;
        @(negedge clock);
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(posedge clock);
        sfr_addr <= a;
        sfr_read <= 1'b1;
        @(negedge clock);
        chk("rdata", e, sfr_rdata);
        chk("hit", {15'h0000, (a >= 8'hfb && a <= 8'hfd)}, sfr_hit);
        @(posedge clock);
        sfr_read <= 1'b0;
    endtask
    task automatic final_report;
        if (fail_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        rd(8'hfd, 8'h00);
        chk("drive", 16'h0000, output_drive_en);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            chk("code", rows[i].c, converter_code);
            rd(rows[i].a, rows[i].r);
        end
        wr(8'hfd, 8'h17);
        chk("alt", 16'h0005, alt_mv);
        chk("def", 16'h0000, def_mv);
        wr(8'hfd, 8'h16);
        chk("alt", 16'h0000, alt_mv);
        wr(8'hfd, 8'h03);
        chk("def", 16'h0004, def_mv);
        @(posedge clock);
        sys_rst <= 1'b1;
        @(posedge clock);
        sys_rst <= 1'b0;
        @(negedge clock);
        chk("def", 16'h0000, def_mv);
        rd(8'hfe, 8'h00);
        final_report();
    end
endmodule
